/* rtl/retimer_ctrl_defines.vh */
/*
 * Register offsets, field positions, reset values and timing counts for the
 * per-channel adaptation, threshold and lock control register bank.
 * Assumes: included by bare name from the design files under rtl/.
 */
`ifndef RETIMER_CTRL_DEFINES_VH
`define RETIMER_CTRL_DEFINES_VH

// Register offsets on the register port.
`define ADDR_ADAPTATION_CONFIG      8'h31
`define ADDR_EYE_INT_THRESHOLDS     8'h32
`define ADDR_FEEDBACK_START_THRESH  8'h33
`define ADDR_LOCK_POWER_TAP         8'h34
// Frequency error count registers; reading them clears the ready flag.
`define ADDR_FREQ_ERR_LOW           8'h3b
`define ADDR_FREQ_ERR_HIGH          8'h3c

// Reset values.
`define RST_ADAPTATION_CONFIG       8'h00
`define RST_EYE_INT_THRESHOLDS      8'h11
`define RST_FEEDBACK_START_THRESH   8'h88
`define RST_LOCK_POWER_TAP          8'h3f

// Field positions.
`define ADAPT_SEQ_HI                6
`define ADAPT_SEQ_LO                5
`define MERIT_SEL_HI                4
`define MERIT_SEL_LO                3
`define FREQ_ERR_READY_BIT          7
`define LOW_POWER_DISABLE_BIT       6
`define LOCK_COUNT_HI               5
`define LOCK_COUNT_LO               4

// Adaptation sequence codes.
`define SEQ_NONE                    2'h0
`define SEQ_LINEAR_ONLY             2'h1
`define SEQ_OPT_FB_LINEAR           2'h2
`define SEQ_LOCK_FB_OPT             2'h3

// Figure of merit codes.
`define MERIT_HORIZONTAL            2'h1
`define MERIT_VERTICAL              2'h2
`define MERIT_BOTH                  2'h3

// Threshold unit in eye-opening counts, as a shift.
`define THRESH_UNIT_SHIFT           3

// Low-power delay after signal loss.
`define LOW_POWER_DELAY_MS          100
`define CLK_FREQ_HZ                 20000000

`endif

/* rtl/lock_recheck.v */
/*
 * Lock-loss recheck counter: holds the lock indication through a number of
 * consecutive failed lock checks before declaring loss of lock.
 * Assumes: check_strobe is a one-cycle pulse per lock evaluation, on clk.
 */
`timescale 1ns/1ps
`default_nettype none

module lock_recheck (
    // Clock and reset.
    input  wire       clk,
    input  wire       reset,
    // Lock evaluation.
    input  wire       check_strobe,
    input  wire       criteria_pass,
    input  wire [1:0] extra_checks,
    // Result.
    output reg        locked
);

    // Number of failed checks seen since the last pass.
    reg [2:0] fail_count;

    // Count failures while locked; a pass restores the count to zero.
    always @(posedge clk) begin
        if (reset) begin
            locked     <= 1'b0;
            fail_count <= 3'h0;
        end else if (check_strobe) begin
            if (criteria_pass) begin
                // Lock is set high and the recheck count restarts.
                locked     <= 1'b1;
                fail_count <= 3'h0;
            end else if (locked) begin
                // First failure plus N rechecks, at most four in all.
                if (fail_count >= {1'b0, extra_checks}) begin
                    locked     <= 1'b0;
                    fail_count <= 3'h0;
                end else begin
                    fail_count <= fail_count + 3'h1;
                end
            end
        end
    end

endmodule // lock_recheck

`default_nettype wire

/* rtl/retimer_adapt_lock_ctrl_regs.v */
/*
 * Per-channel register bank adaptation_config..lock_power_tap_control: adaptation sequence control, eye
 * thresholds, feedback start thresholds, lock recheck, low-power shutdown
 * and the feedback tap limit, plus the small control logic that uses them.
 * Assumes: a simple byte register port (address, write strobe, read strobe)
 * from the serial management or EEPROM loader, synchronous to clk; the
 * analogue equalizer and clock recovery report their status as inputs.
 */
`timescale 1ns/1ps
`default_nettype none
`include "retimer_ctrl_defines.vh"

module retimer_adapt_lock_ctrl_regs #(
    parameter integer LOW_POWER_CYCLES = `LOW_POWER_DELAY_MS * (`CLK_FREQ_HZ / 1000)
) (
    // Clock and reset.
    input  wire       clk,
    input  wire       reset,
    // Register port.
    input  wire [7:0] reg_addr,
    input  wire       reg_write,
    input  wire       reg_read,
    input  wire [7:0] reg_wdata,
    output reg  [7:0] reg_rdata,
    // Control bits held elsewhere in the channel.
    input  wire       linear_eq_adapt_start,
    input  wire       eye_interrupt_enable,
    // Status from the analogue channel.
    input  wire [7:0] horizontal_eye_opening,
    input  wire [7:0] vertical_eye_opening,
    input  wire       eye_measure_valid,
    input  wire       freq_count_done,
    input  wire       signal_detect,
    input  wire       lock_check_strobe,
    input  wire       lock_criteria_pass,
    input  wire       linear_eq_locked,
    input  wire       linear_eq_optimal,
    input  wire       feedback_eq_done,
    // Outputs to the channel.
    output reg        linear_eq_adapt_start_clear,
    output reg        linear_eq_adapt_enable,
    output reg        feedback_eq_adapt_enable,
    output reg  [1:0] equalizer_merit_select,
    output reg  [3:0] feedback_taps_upper_limit,
    output reg  [3:0] feedback_taps_limit_inverted,
    output reg        eye_interrupt_status,
    output reg        channel_power_down,
    output wire       cdr_locked
);

    // Adaptation states.
    localparam [2:0] ST_IDLE      = 3'h0;
    localparam [2:0] ST_LIN_FIRST = 3'h1;
    localparam [2:0] ST_FEEDBACK  = 3'h2;
    localparam [2:0] ST_LIN_LAST  = 3'h3;
    localparam [2:0] ST_DONE      = 3'h4;

    // Low-power counter width; generous for the default 2,000,000 cycles.
    localparam [31:0] LP_LAST = LOW_POWER_CYCLES - 1;

    // Stored registers.
    reg [7:0]  adaptation_config;          // Sequence and merit select.
    reg [7:0]  eye_interrupt_thresholds;   // Interrupt thresholds.
    reg [7:0]  feedback_start_thresholds;  // Minimum openings.
    reg [7:0]  lock_power_tap_control;     // Mixed control and flag.
    reg [2:0]  state;                      // Adaptation state.
    reg [2:0]  next_state;                 // Next adaptation state.
    reg [31:0] lp_count;                   // Cycles since signal loss.

    // Field views.
    wire [1:0]  adapt_sequence = adaptation_config[`ADAPT_SEQ_HI:`ADAPT_SEQ_LO];
    wire [3:0]  horizontal_interrupt_threshold = eye_interrupt_thresholds[7:4];
    wire [3:0]  vertical_interrupt_threshold   = eye_interrupt_thresholds[3:0];
    wire [3:0]  horizontal_feedback_start_min  = feedback_start_thresholds[7:4];
    wire [3:0]  vertical_feedback_start_min    = feedback_start_thresholds[3:0];
    wire        low_power_disable = lock_power_tap_control[`LOW_POWER_DISABLE_BIT];
    wire [1:0]  lock_extra = lock_power_tap_control[`LOCK_COUNT_HI:`LOCK_COUNT_LO];

    // Threshold units scaled to eye-opening counts.
    wire [7:0] h_int_counts = {horizontal_interrupt_threshold, 4'h0} >> 1;
    wire [7:0] v_int_counts = {vertical_interrupt_threshold, 4'h0} >> 1;
    wire [7:0] h_min_counts = {horizontal_feedback_start_min, 4'h0} >> 1;
    wire [7:0] v_min_counts = {vertical_feedback_start_min, 4'h0} >> 1;

    // Openings judged by the programmed figure of merit.
    wire h_used = adaptation_config[`MERIT_SEL_LO];
    wire v_used = adaptation_config[`MERIT_SEL_HI];
    wire eye_below = (h_used && horizontal_eye_opening < h_int_counts) ||
                     (v_used && vertical_eye_opening < v_int_counts);
    // Feedback start under SEQ_LOCK_FB_OPT needs both minimum openings met.
    wire eye_min_met = (horizontal_eye_opening >= h_min_counts) &&
                       (vertical_eye_opening >= v_min_counts);

    // Register writes, the self-setting ready flag and its read clear.
    always @(posedge clk) begin
        if (reset) begin
            adaptation_config         <= `RST_ADAPTATION_CONFIG;
            eye_interrupt_thresholds  <= `RST_EYE_INT_THRESHOLDS;
            feedback_start_thresholds <= `RST_FEEDBACK_START_THRESH;
            lock_power_tap_control    <= `RST_LOCK_POWER_TAP;
        end else begin
            if (reg_write) begin
                case (reg_addr)
                    `ADDR_ADAPTATION_CONFIG:     adaptation_config         <= reg_wdata;
                    `ADDR_EYE_INT_THRESHOLDS:    eye_interrupt_thresholds  <= reg_wdata;
                    `ADDR_FEEDBACK_START_THRESH: feedback_start_thresholds <= reg_wdata;
                    // The ready flag is kept by hardware, not by writes.
                    `ADDR_LOCK_POWER_TAP: lock_power_tap_control[6:0] <= reg_wdata[6:0];
                    default: ;
                endcase
            end
            // A count arriving with the read wins over the clear.
            if (freq_count_done) begin
                lock_power_tap_control[`FREQ_ERR_READY_BIT] <= 1'b1;
            end else if (reg_read && (reg_addr == `ADDR_FREQ_ERR_LOW ||
                                      reg_addr == `ADDR_FREQ_ERR_HIGH)) begin
                lock_power_tap_control[`FREQ_ERR_READY_BIT] <= 1'b0;
            end
        end
    end

    // Registered read data; unmapped offsets read zero.
    always @(posedge clk) begin
        if (reset) begin
            reg_rdata <= 8'h00;
        end else if (reg_read) begin
            case (reg_addr)
                `ADDR_ADAPTATION_CONFIG:     reg_rdata <= adaptation_config;
                `ADDR_EYE_INT_THRESHOLDS:    reg_rdata <= eye_interrupt_thresholds;
                `ADDR_FEEDBACK_START_THRESH: reg_rdata <= feedback_start_thresholds;
                `ADDR_LOCK_POWER_TAP:        reg_rdata <= lock_power_tap_control;
                default:                     reg_rdata <= 8'h00;
            endcase
        end
    end

    // Adaptation sequencing by the programmed sequence code.
    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (linear_eq_adapt_start && adapt_sequence != `SEQ_NONE) begin
                    next_state = ST_LIN_FIRST;
                end
            end
            ST_LIN_FIRST: begin
                if (adapt_sequence == `SEQ_LINEAR_ONLY) begin
                    if (linear_eq_optimal) next_state = ST_DONE;
                end else if (adapt_sequence == `SEQ_OPT_FB_LINEAR) begin
                    if (linear_eq_optimal) next_state = ST_FEEDBACK;
                end else if (adapt_sequence == `SEQ_LOCK_FB_OPT) begin
                    // Lock alone is not enough; minimum openings too.
                    if (linear_eq_locked && eye_measure_valid && eye_min_met) next_state = ST_FEEDBACK;
                end else begin
                    next_state = ST_IDLE;
                end
            end
            ST_FEEDBACK: begin
                if (feedback_eq_done) next_state = ST_LIN_LAST;
            end
            ST_LIN_LAST: begin
                if (linear_eq_optimal) next_state = ST_DONE;
            end
            ST_DONE: begin
                next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // State register and equalizer enables.
    always @(posedge clk) begin
        if (reset) begin
            state                       <= ST_IDLE;
            linear_eq_adapt_enable      <= 1'b0;
            feedback_eq_adapt_enable    <= 1'b0;
            linear_eq_adapt_start_clear <= 1'b0;
        end else begin
            state                    <= next_state;
            linear_eq_adapt_enable   <= (next_state == ST_LIN_FIRST) || (next_state == ST_LIN_LAST);
            feedback_eq_adapt_enable <= (next_state == ST_FEEDBACK);
            // One pulse to self-clear the start bit once taken.
            linear_eq_adapt_start_clear <= (state == ST_IDLE) && linear_eq_adapt_start;
        end
    end

    // Field outputs and eye interrupt status.
    always @(posedge clk) begin
        if (reset) begin
            equalizer_merit_select       <= 2'h0;
            feedback_taps_upper_limit    <= 4'hf;
            feedback_taps_limit_inverted <= 4'hf;
            eye_interrupt_status         <= 1'b0;
        end else begin
            equalizer_merit_select <= adaptation_config[`MERIT_SEL_HI:`MERIT_SEL_LO];
            // One limit feeds both polarities.
            feedback_taps_upper_limit    <= lock_power_tap_control[3:0];
            feedback_taps_limit_inverted <= lock_power_tap_control[3:0];
            // Status follows the live measurement, gated by enable.
            eye_interrupt_status <= eye_interrupt_enable && eye_measure_valid && eye_below;
        end
    end

    // Low-power shutdown timer; power returns as soon as signal is back.
    always @(posedge clk) begin
        if (reset) begin
            lp_count           <= 32'h0;
            channel_power_down <= 1'b0;
        end else if (signal_detect || low_power_disable) begin
            lp_count           <= 32'h0;
            channel_power_down <= 1'b0;
        end else if (lp_count >= LP_LAST) begin
            channel_power_down <= 1'b1;
        end else begin
            lp_count <= lp_count + 32'h1;
        end
    end

    // Lock recheck counter.
    lock_recheck u_lock_recheck (
        .clk           (clk),
        .reset         (reset),
        .check_strobe  (lock_check_strobe),
        .criteria_pass (lock_criteria_pass),
        .extra_checks  (lock_extra),
        .locked        (cdr_locked)
    );

endmodule // retimer_adapt_lock_ctrl_regs

`default_nettype wire

/* test/retimer_ctrl_asserts.sv */
/* Port-level checks for the adaptation, threshold and lock register bank.
   Assumes: bound into retimer_adapt_lock_ctrl_regs, one clock, sync reset. */
`timescale 1ns/1ps
`default_nettype none
module retimer_ctrl_asserts (
    // Clock and reset.
    input wire logic       clk,
    input wire logic       reset,
    // Inputs that cause output changes.
    input wire logic       reg_write,
    input wire logic       linear_eq_adapt_start,
    input wire logic       eye_interrupt_enable,
    input wire logic       signal_detect,
    input wire logic       lock_check_strobe,
    input wire logic       lock_criteria_pass,
    // Outputs watched.
    input wire logic       linear_eq_adapt_start_clear,
    input wire logic [1:0] equalizer_merit_select,
    input wire logic [3:0] feedback_taps_upper_limit,
    input wire logic [3:0] feedback_taps_limit_inverted,
    input wire logic       eye_interrupt_status,
    input wire logic       channel_power_down,
    input wire logic       cdr_locked
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // A lock evaluation that passes its criteria.
    sequence s_pass; lock_check_strobe && lock_criteria_pass; endsequence
    // The start-clear strobe lasts a single cycle.
    sequence s_clear_once; linear_eq_adapt_start_clear ##1 !linear_eq_adapt_start_clear; endsequence
    property p_clear; $rose(linear_eq_adapt_start_clear) |-> $past(linear_eq_adapt_start) ##0 s_clear_once; endproperty
    property p_tap_pol; feedback_taps_limit_inverted == feedback_taps_upper_limit; endproperty
    // Field outputs trail the register by one cycle, so a write two samples back is what moves them.
    property p_tap_hold; !$past(reg_write) |=> $stable(feedback_taps_upper_limit); endproperty
    property p_merit_hold; !$past(reg_write) |=> $stable(equalizer_merit_select); endproperty
    property p_int_en; !eye_interrupt_enable |=> !eye_interrupt_status; endproperty
    property p_pd_wake; signal_detect |=> !channel_power_down; endproperty
    property p_pd_late; $rose(channel_power_down) |-> !$past(signal_detect, 8) && !$past(signal_detect); endproperty
    property p_lock_keep; cdr_locked ##0 s_pass |=> cdr_locked; endproperty
    a_clear: assert property (p_clear) else $error("start clear not a single caused pulse");
    a_tap_pol: assert property (p_tap_pol) else $error("tap limit differs by polarity");
    a_tap_hold: assert property (p_tap_hold) else $error("tap limit moved without write");
    a_merit_hold: assert property (p_merit_hold) else $error("merit select moved without write");
    a_int_en: assert property (p_int_en) else $error("eye status while disabled");
    a_pd_wake: assert property (p_pd_wake) else $error("power down with signal present");
    a_pd_late: assert property (p_pd_late) else $error("power down too early");
    a_lock_keep: assert property (p_lock_keep) else $error("lock lost on passing check");
endmodule // retimer_ctrl_asserts
bind retimer_adapt_lock_ctrl_regs retimer_ctrl_asserts retimer_ctrl_asserts_inst (.*);
`default_nettype wire

/* test/tb.sv */
/* Self-checking bench for the register bank and its control logic.
   Assumes: the bench stands in for the register master and analogue side. */
`timescale 1ns/1ps
`default_nettype none
module tb;
    // Stimulus, all given values at time zero.
    logic clk = 0, reset = 1, reg_write = 0, reg_read = 0, linear_eq_adapt_start = 0;
    logic [7:0] reg_addr = 0, reg_wdata = 0, horizontal_eye_opening = 0, vertical_eye_opening = 0;
    logic eye_interrupt_enable = 0, eye_measure_valid = 0, freq_count_done = 0, signal_detect = 1;
    logic lock_check_strobe = 0, lock_criteria_pass = 0, linear_eq_locked = 0;
    logic linear_eq_optimal = 0, feedback_eq_done = 0;
    // Design outputs.
    wire [7:0] reg_rdata;
    wire [3:0] feedback_taps_upper_limit, feedback_taps_limit_inverted;
    wire [1:0] equalizer_merit_select;
    wire linear_eq_adapt_start_clear, linear_eq_adapt_enable, feedback_eq_adapt_enable;
    wire eye_interrupt_status, channel_power_down, cdr_locked;
    logic [7:0] d;
    integer fails = 0, checks_done = 0, n;
    // A short power-down delay keeps the run brief.
    retimer_adapt_lock_ctrl_regs #(.LOW_POWER_CYCLES(20)) retimer_adapt_lock_ctrl_regs_inst (.*);
    always #25 clk = ~clk;
    task test_done;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done = checks_done + 1;
        if (got !== exp) begin
            fails = fails + 1;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task tick(input integer k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_write <= 1;
        @(posedge clk);
        reg_write <= 0;
    endtask
    // Read data lands on the edge that takes the strobe.
    task rd(input logic [7:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1;
        @(posedge clk);
        reg_read <= 0;
        #1 d = reg_rdata;
    endtask
    function logic sig(input integer s);
        case (s)
            0: sig = linear_eq_adapt_enable;
            1: sig = feedback_eq_adapt_enable;
            default: sig = channel_power_down;
        endcase
    endfunction
    // Bounded wait; running out ends the run.
    task wt(input integer s, input logic v);
        #1;
        for (n = 0; n < 60 && sig(s) !== v; n = n + 1) tick(1);
        if (n == 60) begin
            fails = fails + 1;
            $display("[ERR] %0t wait expired", $time);
            test_done;
        end
    endtask
    task kick;
        @(posedge clk);
        linear_eq_adapt_start <= 1;
        @(posedge clk);
        linear_eq_adapt_start <= 0;
        #1 chk(linear_eq_adapt_start_clear, 1);
    endtask
    task eye(input logic [7:0] h, input logic [7:0] v, input logic en, input logic ex);
        @(posedge clk);
        horizontal_eye_opening <= h;
        vertical_eye_opening <= v;
        eye_interrupt_enable <= en;
        eye_measure_valid <= 1;
        tick(3);
        chk(eye_interrupt_status, ex);
    endtask
    task strobe(input logic p, input logic ex);
        @(posedge clk);
        lock_check_strobe <= 1;
        lock_criteria_pass <= p;
        @(posedge clk);
        lock_check_strobe <= 0;
        tick(2);
        chk(cdr_locked, ex);
    endtask
    // Reset values, an unmapped read and the read-only ready bit.
    task t_regs;
        logic [39:0] e;
        e = 40'h00_11_88_3f_00;
        for (n = 0; n < 5; n = n + 1) begin
            rd(8'h31 + n[7:0]);
            chk(d, e[8*(4-n) +: 8]);
        end
        chk(feedback_taps_limit_inverted, 8'h0f);
        wr(8'h34, 8'ha5);
        rd(8'h34);
        chk(d, 8'h25);
        chk(feedback_taps_upper_limit, 8'h05);
        @(posedge clk);
        freq_count_done <= 1;
        @(posedge clk);
        freq_count_done <= 0;
        rd(8'h34);
        chk(d[7], 1);
        rd(8'h3b);
        rd(8'h34);
        chk(d[7], 0);
        for (n = 1; n < 4; n = n + 1) begin
            wr(8'h31, {3'h0, n[1:0], 3'h0});
            tick(1);
            chk(equalizer_merit_select, n[7:0]);
        end
    endtask
    // Thresholds: horizontal 2 units, vertical 3 units.
    task t_eye;
        wr(8'h32, 8'h23);
        eye(8'h14, 8'h1e, 1, 0);
        eye(8'h0f, 8'h1e, 1, 1);
        eye(8'h10, 8'h1e, 1, 0);
        eye(8'h14, 8'h17, 1, 1);
        eye(8'h14, 8'h17, 0, 0);
        wr(8'h31, 8'h08);
        eye(8'h14, 8'h17, 1, 0);
        eye(8'h0f, 8'h1e, 1, 1);
        eye(8'h40, 8'h40, 0, 0);
    endtask
    task t_adapt;
        wr(8'h31, 8'h18);
        kick;
        tick(2);
        chk(linear_eq_adapt_enable, 0);
        wr(8'h31, 8'h38);
        kick;
        chk(linear_eq_adapt_enable, 1);
        @(posedge clk);
        linear_eq_optimal <= 1;
        wt(0, 0);
        chk(feedback_eq_adapt_enable, 0);
        @(posedge clk);
        linear_eq_optimal <= 0;
        wr(8'h31, 8'h58);
        kick;
        @(posedge clk);
        linear_eq_optimal <= 1;
        wt(1, 1);
        @(posedge clk);
        linear_eq_optimal <= 0;
        feedback_eq_done <= 1;
        wt(0, 1);
        @(posedge clk);
        feedback_eq_done <= 0;
        linear_eq_optimal <= 1;
        wt(0, 0);
        @(posedge clk);
        linear_eq_optimal <= 0;
        wr(8'h33, 8'h22);
        wr(8'h31, 8'h78);
        eye(8'h08, 8'h1e, 0, 0);
        kick;
        @(posedge clk);
        linear_eq_locked <= 1;
        tick(5);
        chk(feedback_eq_adapt_enable, 0);
        @(posedge clk);
        horizontal_eye_opening <= 8'h10;
        wt(1, 1);
        @(posedge clk);
        feedback_eq_done <= 1;
        wt(0, 1);
        @(posedge clk);
        linear_eq_optimal <= 1;
        wt(0, 0);
    endtask
    // One extra check allowed, so the second failure in a row drops lock.
    task t_lock;
        wr(8'h34, 8'h1f);
        strobe(1, 1);
        strobe(0, 1);
        strobe(1, 1);
        strobe(0, 1);
        strobe(0, 0);
    endtask
    task t_power;
        wr(8'h34, 8'h5f);
        signal_detect <= 0;
        tick(30);
        chk(channel_power_down, 0);
        @(posedge clk);
        signal_detect <= 1;
        wr(8'h34, 8'h1f);
        signal_detect <= 0;
        wt(2, 1);
        chk(n >= 17 && n <= 23, 1);
        @(posedge clk);
        signal_detect <= 1;
        tick(2);
        chk(channel_power_down, 0);
    endtask
    initial begin
        repeat (12) @(posedge clk);
        reset <= 0;
        t_regs;
        t_eye;
        t_adapt;
        t_lock;
        t_power;
        test_done;
    end
endmodule // tb
`default_nettype wire
